/* logic/cwb_pkg.sv */
// shared constants and types of the colour balance and ycc stage
package cwb_pkg;
	// ----------------------------------------------------------------
	// gains: unsigned fixed point with ten fraction bits
	// ----------------------------------------------------------------
	localparam int GW = 13;
	localparam int GAIN_FRAC = 10;
	localparam logic [12:0] GAIN_ONE = 13'h0400;
	localparam logic [12:0] GAIN_MAX = 13'h1000;
	// manual gains arrive in hundredths
	localparam int HW = 9;
	localparam logic [8:0] HUND_MIN = 9'h064;
	localparam logic [8:0] HUND_MAX = 9'h190;
	localparam logic [13:0] HUND_SCALE = 14'h28F6;
	// ----------------------------------------------------------------
	// luminance and saturation factors: eight fraction bits
	// ----------------------------------------------------------------
	localparam int FW = 11;
	localparam int FACT_FRAC = 8;
	localparam logic [10:0] FACT_ONE = 11'h100;
	localparam logic [10:0] FACT_MAX = 11'h400;
	// ----------------------------------------------------------------
	// conversion matrix, magnitudes over 32768
	// ----------------------------------------------------------------
	localparam int CONV_SHIFT = 15;
	localparam logic signed [31:0] Y_R = 32'sh0000_2646;
	localparam logic signed [31:0] Y_G = 32'sh0000_4B23;
	localparam logic signed [31:0] Y_B = 32'sh0000_0E98;
	localparam logic signed [31:0] CB_R = 32'sh0000_1599;
	localparam logic signed [31:0] CB_G = 32'sh0000_2A67;
	localparam logic signed [31:0] CB_B = 32'sh0000_4000;
	localparam logic signed [31:0] CR_R = 32'sh0000_4000;
	localparam logic signed [31:0] CR_G = 32'sh0000_3598;
	localparam logic signed [31:0] CR_B = 32'sh0000_0A68;
	// chroma offset per datapath depth
	localparam logic signed [31:0] OFS_8 = 32'sh0000_0080;
	localparam logic signed [31:0] OFS_10 = 32'sh0000_0200;
	localparam logic signed [31:0] OFS_12 = 32'sh0000_0800;
	// ----------------------------------------------------------------
	// timing
	// ----------------------------------------------------------------
	localparam int PERIOD_MS = 10;
	localparam int CLK_KHZ = 200000;
	localparam int PERIOD_CYC = PERIOD_MS * CLK_KHZ;
	// ----------------------------------------------------------------
	// modes, channels, states
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		MODE_OFF = 2'h0,
		MODE_PERIODIC = 2'h1,
		MODE_ONCE = 2'h2
	} cwb_mode_t;
	typedef enum logic [1:0] {
		REF_RED = 2'h0,
		REF_GREEN = 2'h1,
		REF_BLUE = 2'h2,
		REF_AUTO = 2'h3
	} cwb_ref_t;
	typedef enum logic [3:0] {
		ST_IDLE = 4'h1,
		ST_ARM = 4'h2,
		ST_ACC = 4'h4,
		ST_DIV = 4'h8
	} cwb_state_t;
endpackage

/* logic/cwb_divider.sv */
// serial restoring divider for the automatic gain ratios
`timescale 1ns/1ps
module cwb_divider #(
	parameter int NW = 50,
	parameter int DWD = 40
) (
	input wire logic clk_i,
	input wire logic reset_n_i,
	input wire logic start_i,
	input wire logic [NW-1:0] num_i,
	input wire logic [DWD-1:0] den_i,
	output logic done_o,
	output logic [NW-1:0] quo_o
);
	localparam int CW = $clog2(NW + 1);
	localparam logic [CW-1:0] LAST = CW'(NW - 1);

	logic [DWD:0] rem_ff, nxt_rem;
	logic [NW-1:0] quo_ff, nxt_quo;
	logic [DWD-1:0] den_ff, nxt_den;
	logic [CW-1:0] cnt_ff, nxt_cnt;
	logic run_ff, nxt_run;
	logic done_ff, nxt_done;
	logic [DWD+1:0] shifted;
	logic [DWD+1:0] diff;

	// divide by zero gives all ones, which the caller clamps
	always_comb begin
		nxt_rem = rem_ff;
		nxt_quo = quo_ff;
		nxt_den = den_ff;
		nxt_cnt = cnt_ff;
		nxt_run = run_ff;
		nxt_done = 1'b0;
		shifted = {rem_ff, quo_ff[NW-1]};
		diff = shifted - {2'h0, den_ff};
		if (start_i) begin
			nxt_rem = '0;
			nxt_quo = num_i;
			nxt_den = den_i;
			nxt_cnt = '0;
			nxt_run = 1'b1;
		end else if (run_ff) begin
			if (!diff[DWD+1]) begin
				nxt_rem = diff[DWD:0];
				nxt_quo = {quo_ff[NW-2:0], 1'b1};
			end else begin
				nxt_rem = shifted[DWD:0];
				nxt_quo = {quo_ff[NW-2:0], 1'b0};
			end
			nxt_cnt = cnt_ff + CW'(1);
			if (cnt_ff == LAST) begin
				nxt_run = 1'b0;
				nxt_done = 1'b1;
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (!reset_n_i) begin
			rem_ff <= '0;
			quo_ff <= '0;
			den_ff <= '0;
			cnt_ff <= '0;
			run_ff <= 1'b0;
			done_ff <= 1'b0;
		end else begin
			rem_ff <= nxt_rem;
			quo_ff <= nxt_quo;
			den_ff <= nxt_den;
			cnt_ff <= nxt_cnt;
			run_ff <= nxt_run;
			done_ff <= nxt_done;
		end
	end

	assign done_o = done_ff;
	assign quo_o = quo_ff;
endmodule // cwb_divider

/* logic/cwb_color_proc.sv */
// white balance gains, rgb to ycc conversion, luma and saturation factors
`timescale 1ns/1ps
module cwb_color_proc #(
	parameter int DW = 12,
	parameter int SW = 40,
	parameter int PERIOD_CYC = cwb_pkg::PERIOD_CYC
) (
	input wire logic clk_i,
	input wire logic reset_n_i,
	input wire logic pix_valid_i,
	input wire logic pix_sof_i,
	input wire logic pix_eof_i,
	input wire logic [DW-1:0] pix_r_i,
	input wire logic [DW-1:0] pix_g_i,
	input wire logic [DW-1:0] pix_b_i,
	input wire logic [1:0] auto_balance_mode_i,
	input wire logic balance_once_command_i,
	input wire logic [1:0] reference_channel_pick_i,
	input wire logic [1:0] gain_channel_select_i,
	input wire logic [cwb_pkg::HW-1:0] channel_gain_value_i,
	input wire logic gain_write_i,
	input wire logic [cwb_pkg::FW-1:0] saturation_i,
	input wire logic [cwb_pkg::FW-1:0] luminance_i,
	output logic out_valid_o,
	output logic out_sof_o,
	output logic out_eof_o,
	output logic [DW-1:0] y_o,
	output logic [DW-1:0] cb_o,
	output logic [DW-1:0] cr_o,
	output logic [cwb_pkg::GW-1:0] channel_gain_value_o,
	output logic [1:0] ref_channel_o,
	output logic balance_busy_o
);
	// ----------------------------------------------------------------
	// elaboration checks
	// ----------------------------------------------------------------
	if (DW != 8 && DW != 10 && DW != 12) begin : g_bad_dw
		$error("cwb_color_proc: DW must be 8, 10 or 12");
	end
	if (SW < 2 * DW || SW > 48) begin : g_bad_sw
		$error("cwb_color_proc: SW out of range");
	end
	if (PERIOD_CYC < 2) begin : g_bad_per
		$error("cwb_color_proc: PERIOD_CYC too small");
	end

	localparam int GW = cwb_pkg::GW;
	localparam int NW = SW + cwb_pkg::GAIN_FRAC;
	localparam logic signed [31:0] CHROMA_OFS = (DW == 8) ? cwb_pkg::OFS_8 :
		(DW == 10) ? cwb_pkg::OFS_10 : cwb_pkg::OFS_12;
	localparam logic signed [31:0] PIX_MAX = (32'sh1 <<< DW) - 32'sh1;
	localparam logic [31:0] PER_LAST = 32'(PERIOD_CYC - 1);

	function automatic logic [DW-1:0] clamp_px(input logic signed [31:0] v);
		if (v < 0)
			return '0;
		else if (v > PIX_MAX)
			return PIX_MAX[DW-1:0];
		else
			return v[DW-1:0];
	endfunction

	function automatic logic [cwb_pkg::FW-1:0] clamp_fact(
		input logic [cwb_pkg::FW-1:0] f);
		if (f < cwb_pkg::FACT_ONE)
			return cwb_pkg::FACT_ONE;
		else if (f > cwb_pkg::FACT_MAX)
			return cwb_pkg::FACT_MAX;
		else
			return f;
	endfunction

	// ----------------------------------------------------------------
	// periodic timer and pending balance request
	// ----------------------------------------------------------------
	logic [31:0] per_cnt_ff, nxt_per_cnt;
	logic pend_ff, nxt_pend;
	logic per_tick;
	logic pend_clr;
	cwb_pkg::cwb_state_t st_ff, nxt_st;

	always_comb begin
		nxt_per_cnt = '0;
		per_tick = 1'b0;
		if (auto_balance_mode_i == cwb_pkg::MODE_PERIODIC) begin
			if (per_cnt_ff >= PER_LAST)
				per_tick = 1'b1;
			else
				nxt_per_cnt = per_cnt_ff + 32'h1;
		end
		pend_clr = (st_ff == cwb_pkg::ST_IDLE) && pend_ff;
		// a new request in the clearing cycle is kept
		nxt_pend = (pend_ff && !pend_clr) || per_tick ||
			(auto_balance_mode_i == cwb_pkg::MODE_ONCE &&
			balance_once_command_i);
		if (auto_balance_mode_i == cwb_pkg::MODE_OFF)
			nxt_pend = 1'b0;
	end

	always_ff @(posedge clk_i) begin
		if (!reset_n_i) begin
			per_cnt_ff <= '0;
			pend_ff <= 1'b0;
		end else begin
			per_cnt_ff <= nxt_per_cnt;
			pend_ff <= nxt_pend;
		end
	end

	// ----------------------------------------------------------------
	// frame statistics and automatic balance sequencer
	// ----------------------------------------------------------------
	logic [SW-1:0] sum_ff [3];
	logic [SW-1:0] nxt_sum [3];
	logic [1:0] ref_ff, nxt_ref;
	logic [1:0] ch_ff, nxt_ch;
	logic start_ff, nxt_start;
	logic [GW-1:0] gain_ff [3];
	logic [GW-1:0] nxt_gain [3];
	logic div_done;
	logic [NW-1:0] div_quo;
	logic [NW-1:0] div_num;
	logic [SW-1:0] div_den;
	logic [22:0] man_prod;
	logic [cwb_pkg::HW-1:0] man_h;
	logic [1:0] auto_ref;
	logic [DW-1:0] pix_in [3];

	assign pix_in[0] = pix_r_i;
	assign pix_in[1] = pix_g_i;
	assign pix_in[2] = pix_b_i;

	always_comb begin
		nxt_st = st_ff;
		nxt_ref = ref_ff;
		nxt_ch = ch_ff;
		nxt_start = 1'b0;
		nxt_sum = sum_ff;
		nxt_gain = gain_ff;
		man_h = channel_gain_value_i;
		man_prod = '0;
		// the largest sum becomes reference so the smallest gain is 1.00
		if (sum_ff[0] >= sum_ff[1] && sum_ff[0] >= sum_ff[2])
			auto_ref = cwb_pkg::REF_RED;
		else if (sum_ff[1] >= sum_ff[2])
			auto_ref = cwb_pkg::REF_GREEN;
		else
			auto_ref = cwb_pkg::REF_BLUE;
		case (st_ff)
		cwb_pkg::ST_IDLE: begin
			if (pend_ff)
				nxt_st = cwb_pkg::ST_ARM;
		end
		cwb_pkg::ST_ARM: begin
			if (auto_balance_mode_i == cwb_pkg::MODE_OFF) begin
				nxt_st = cwb_pkg::ST_IDLE;
			end else if (pix_valid_i && pix_sof_i) begin
				for (int i = 0; i < 3; i++)
					nxt_sum[i] = SW'(pix_in[i]);
				nxt_st = cwb_pkg::ST_ACC;
			end
		end
		cwb_pkg::ST_ACC: begin
			if (pix_valid_i) begin
				for (int i = 0; i < 3; i++)
					nxt_sum[i] = sum_ff[i] + SW'(pix_in[i]);
				if (pix_eof_i) begin
					nxt_st = cwb_pkg::ST_DIV;
					nxt_ch = 2'h0;
					nxt_start = 1'b1;
				end
			end
		end
		cwb_pkg::ST_DIV: begin
			if (reference_channel_pick_i == cwb_pkg::REF_AUTO)
				nxt_ref = auto_ref;
			else
				nxt_ref = reference_channel_pick_i;
			if (div_done) begin
				// full ten-bit fraction kept, finer than 0.01
				if (ch_ff == nxt_ref)
					nxt_gain[ch_ff] = cwb_pkg::GAIN_ONE;
				else if (div_quo > NW'(cwb_pkg::GAIN_MAX))
					nxt_gain[ch_ff] = cwb_pkg::GAIN_MAX;
				else if (div_quo < NW'(cwb_pkg::GAIN_ONE))
					nxt_gain[ch_ff] = cwb_pkg::GAIN_ONE;
				else
					nxt_gain[ch_ff] = div_quo[GW-1:0];
				if (ch_ff == 2'h2) begin
					nxt_st = cwb_pkg::ST_IDLE;
				end else begin
					nxt_ch = ch_ff + 2'h1;
					nxt_start = 1'b1;
				end
			end
		end
		default: begin
			nxt_st = cwb_pkg::ST_IDLE;
		end
		endcase
		// manual writes only count while automatic balance is off
		if (auto_balance_mode_i == cwb_pkg::MODE_OFF && gain_write_i &&
			gain_channel_select_i != 2'h3) begin
			if (man_h < cwb_pkg::HUND_MIN)
				man_h = cwb_pkg::HUND_MIN;
			else if (man_h > cwb_pkg::HUND_MAX)
				man_h = cwb_pkg::HUND_MAX;
			man_prod = man_h * cwb_pkg::HUND_SCALE;
			nxt_gain[gain_channel_select_i] = man_prod[22:10];
		end
	end

	always_ff @(posedge clk_i) begin
		if (!reset_n_i) begin
			st_ff <= cwb_pkg::ST_IDLE;
			ref_ff <= cwb_pkg::REF_GREEN;
			ch_ff <= 2'h0;
			start_ff <= 1'b0;
			for (int i = 0; i < 3; i++) begin
				sum_ff[i] <= '0;
				gain_ff[i] <= cwb_pkg::GAIN_ONE;
			end
		end else begin
			st_ff <= nxt_st;
			ref_ff <= nxt_ref;
			ch_ff <= nxt_ch;
			start_ff <= nxt_start;
			sum_ff <= nxt_sum;
			gain_ff <= nxt_gain;
		end
	end

	// reference sum over channel sum gives the ratio in gain format
	// picked reference read directly: ref_ff lags the first divide start
	assign div_num = {sum_ff[nxt_ref], {cwb_pkg::GAIN_FRAC{1'b0}}};
	assign div_den = sum_ff[ch_ff];

	cwb_divider #(
		.NW(NW),
		.DWD(SW)
	) u_div (
		.clk_i(clk_i),
		.reset_n_i(reset_n_i),
		.start_i(start_ff),
		.num_i(div_num),
		.den_i(div_den),
		.done_o(div_done),
		.quo_o(div_quo)
	);

	// ----------------------------------------------------------------
	// stage 1: white balance gains per channel
	// ----------------------------------------------------------------
	logic [DW-1:0] wb_ff [3];
	logic [DW-1:0] nxt_wb [3];
	logic [2:0] ctl1_ff, ctl2_ff, nxt_ctl1, nxt_ctl2;

	for (genvar c = 0; c < 3; c++) begin : g_wb
		logic [DW+GW-1:0] prod;
		always_comb begin
			prod = pix_in[c] * gain_ff[c];
			nxt_wb[c] = clamp_px(32'(prod >> cwb_pkg::GAIN_FRAC));
		end
		always_ff @(posedge clk_i) begin
			if (!reset_n_i)
				wb_ff[c] <= '0;
			else
				wb_ff[c] <= nxt_wb[c];
		end
	end

	// ----------------------------------------------------------------
	// stage 2: matrix, stage 3: factors, offset and clamp
	// ----------------------------------------------------------------
	logic signed [31:0] ys_ff, cbs_ff, crs_ff, nxt_ys, nxt_cbs, nxt_crs;
	logic signed [31:0] r_s, g_s, b_s, sat_s, lum_s;
	logic [DW-1:0] nxt_y, nxt_cb, nxt_cr;

	always_comb begin
		nxt_ctl1 = {pix_valid_i, pix_sof_i, pix_eof_i};
		nxt_ctl2 = ctl1_ff;
		r_s = $signed({{(32 - DW){1'b0}}, wb_ff[0]});
		g_s = $signed({{(32 - DW){1'b0}}, wb_ff[1]});
		b_s = $signed({{(32 - DW){1'b0}}, wb_ff[2]});
		nxt_ys = (cwb_pkg::Y_R * r_s + cwb_pkg::Y_G * g_s +
			cwb_pkg::Y_B * b_s) >>> cwb_pkg::CONV_SHIFT;
		nxt_cbs = (cwb_pkg::CB_B * b_s - cwb_pkg::CB_R * r_s -
			cwb_pkg::CB_G * g_s) >>> cwb_pkg::CONV_SHIFT;
		nxt_crs = (cwb_pkg::CR_R * r_s - cwb_pkg::CR_G * g_s -
			cwb_pkg::CR_B * b_s) >>> cwb_pkg::CONV_SHIFT;
		// factors below one are raised to one: both controls only boost
		sat_s = $signed({21'h0, clamp_fact(saturation_i)});
		lum_s = $signed({21'h0, clamp_fact(luminance_i)});
		nxt_y = clamp_px((ys_ff * lum_s) >>> cwb_pkg::FACT_FRAC);
		nxt_cb = clamp_px(((cbs_ff * sat_s) >>> cwb_pkg::FACT_FRAC) +
			CHROMA_OFS);
		nxt_cr = clamp_px(((crs_ff * sat_s) >>> cwb_pkg::FACT_FRAC) +
			CHROMA_OFS);
	end

	always_ff @(posedge clk_i) begin
		if (!reset_n_i) begin
			ctl1_ff <= 3'h0;
			ctl2_ff <= 3'h0;
			ys_ff <= '0;
			cbs_ff <= '0;
			crs_ff <= '0;
			{out_valid_o, out_sof_o, out_eof_o} <= 3'h0;
			y_o <= '0;
			cb_o <= '0;
			cr_o <= '0;
			channel_gain_value_o <= cwb_pkg::GAIN_ONE;
			ref_channel_o <= cwb_pkg::REF_GREEN;
			balance_busy_o <= 1'b0;
		end else begin
			ctl1_ff <= nxt_ctl1;
			ctl2_ff <= nxt_ctl2;
			ys_ff <= nxt_ys;
			cbs_ff <= nxt_cbs;
			crs_ff <= nxt_crs;
			{out_valid_o, out_sof_o, out_eof_o} <= ctl2_ff;
			y_o <= nxt_y;
			cb_o <= nxt_cb;
			cr_o <= nxt_cr;
			if (gain_channel_select_i != 2'h3)
				channel_gain_value_o <= gain_ff[gain_channel_select_i];
			ref_channel_o <= ref_ff;
			balance_busy_o <= (nxt_st != cwb_pkg::ST_IDLE);
		end
	end
endmodule // cwb_color_proc

/* sim/cwb_color_proc_properties.sv */
// port assertions of the colour balance and ycc stage
`timescale 1ns/1ps
module cwb_color_proc_chk #(
	parameter int DW = 12,
	parameter int PERIOD_CYC = 200
) (
	input wire logic clk_i,
	input wire logic reset_n_i,
	input wire logic pix_valid_i,
	input wire logic pix_sof_i,
	input wire logic pix_eof_i,
	input wire logic [1:0] auto_balance_mode_i,
	input wire logic balance_once_command_i,
	input wire logic [1:0] gain_channel_select_i,
	input wire logic [cwb_pkg::HW-1:0] channel_gain_value_i,
	input wire logic gain_write_i,
	input wire logic out_valid_o,
	input wire logic out_sof_o,
	input wire logic out_eof_o,
	input wire logic [cwb_pkg::GW-1:0] channel_gain_value_o,
	input wire logic [1:0] ref_channel_o,
	input wire logic balance_busy_o
);
	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	int idle_ff;
	int nxt_idle;
	// idle stretch in periodic mode, cleared whenever a run is busy
	always_comb begin
		nxt_idle = 0;
		if (auto_balance_mode_i == 2'h1 && !balance_busy_o)
			nxt_idle = idle_ff + 1;
	end
	always_ff @(posedge clk_i) begin
		if (!reset_n_i)
			idle_ff <= 0;
		else
			idle_ff <= nxt_idle;
	end
	function automatic logic [12:0] hund_gain(input logic [8:0] h);
		logic [8:0] c;
		c = h;
		if (c < cwb_pkg::HUND_MIN)
			c = cwb_pkg::HUND_MIN;
		if (c > cwb_pkg::HUND_MAX)
			c = cwb_pkg::HUND_MAX;
		return 13'((24'(c) * 24'(cwb_pkg::HUND_SCALE)) >> 10);
	endfunction
	// ----------------------------------------------------------------
	// properties
	// ----------------------------------------------------------------
	default clocking cb_clk @(posedge clk_i);
	endclocking
	default disable iff (!reset_n_i);
	sequence seq_write;
		gain_write_i && auto_balance_mode_i == 2'h0 &&
			gain_channel_select_i != 2'h3 && !balance_busy_o;
	endsequence
	sequence seq_run_end;
		($fell(balance_busy_o) && auto_balance_mode_i != 2'h0) ##1
			($stable(gain_channel_select_i) && !gain_write_i &&
			gain_channel_select_i == ref_channel_o)[*2];
	endsequence
	AST_LATENCY: assert property (pix_valid_i |-> ##3
		(out_valid_o && out_sof_o == $past(pix_sof_i, 3) &&
		out_eof_o == $past(pix_eof_i, 3)))
		else $error("pixel beat not shown three cycles later");
	AST_NO_SPURIOUS: assert property (!pix_valid_i |-> ##3
		!out_valid_o) else $error("output beat without input beat");
	AST_GAIN_RANGE: assert property (
		channel_gain_value_o >= cwb_pkg::GAIN_ONE &&
		channel_gain_value_o <= cwb_pkg::GAIN_MAX)
		else $error("gain readout outside one to four");
	AST_WRITE: assert property (seq_write ##1
		$stable(gain_channel_select_i) |-> ##1 channel_gain_value_o ==
		hund_gain($past(channel_gain_value_i, 2)))
		else $error("manual gain readout wrong");
	AST_ONCE_QUIET: assert property (auto_balance_mode_i == 2'h2 &&
		$past(auto_balance_mode_i) == 2'h2 &&
		$past(auto_balance_mode_i, 2) == 2'h2 &&
		!balance_once_command_i && !$past(balance_once_command_i) &&
		!balance_busy_o && !$past(balance_busy_o) |=> !balance_busy_o)
		else $error("one-shot balance started without command");
	AST_CMD_ARMS: assert property ((auto_balance_mode_i == 2'h2 &&
		balance_once_command_i && !balance_busy_o) ##1
		auto_balance_mode_i == 2'h2 |-> ##1 balance_busy_o)
		else $error("command did not arm the balance");
	AST_PERIOD: assert property (idle_ff <= PERIOD_CYC + 4)
		else $error("periodic balance did not start in time");
	AST_REF_GAIN: assert property (seq_run_end |->
		channel_gain_value_o == cwb_pkg::GAIN_ONE)
		else $error("reference channel gain not unity");
endmodule // cwb_color_proc_chk
bind cwb_color_proc cwb_color_proc_chk #(
	.DW(DW),
	.PERIOD_CYC(PERIOD_CYC)
) i_chk (
	.clk_i(clk_i),
	.reset_n_i(reset_n_i),
	.pix_valid_i(pix_valid_i),
	.pix_sof_i(pix_sof_i),
	.pix_eof_i(pix_eof_i),
	.auto_balance_mode_i(auto_balance_mode_i),
	.balance_once_command_i(balance_once_command_i),
	.gain_channel_select_i(gain_channel_select_i),
	.channel_gain_value_i(channel_gain_value_i),
	.gain_write_i(gain_write_i),
	.out_valid_o(out_valid_o),
	.out_sof_o(out_sof_o),
	.out_eof_o(out_eof_o),
	.channel_gain_value_o(channel_gain_value_o),
	.ref_channel_o(ref_channel_o),
	.balance_busy_o(balance_busy_o)
);

/* sim/cwb_pix_src.sv */
// upstream pixel source model feeding frames to the colour stage
`timescale 1ns/1ps
module cwb_pix_src #(
	parameter int DW = 8
) (
	input wire logic clk_i,
	output logic pix_valid_o,
	output logic pix_sof_o,
	output logic pix_eof_o,
	output logic [DW-1:0] pix_r_o,
	output logic [DW-1:0] pix_g_o,
	output logic [DW-1:0] pix_b_o
);
	// idle beats carry inverted data so a stale pixel cannot pass
	task automatic idle();
		pix_valid_o = 1'b0;
		pix_sof_o = 1'b0;
		pix_eof_o = 1'b0;
		pix_r_o = ~pix_r_o;
		pix_g_o = ~pix_g_o;
		pix_b_o = ~pix_b_o;
	endtask
	initial begin
		pix_r_o = '0;
		pix_g_o = '0;
		pix_b_o = '0;
		idle();
	end
	// gap inserts idle cycles between beats, a slow sensor
	task automatic send_frame(input int len, input logic [DW-1:0] r,
		input logic [DW-1:0] g, input logic [DW-1:0] b, input int gap);
		for (int k = 0; k < len; k++) begin
			@(negedge clk_i);
			pix_valid_o = 1'b1;
			pix_sof_o = (k == 0);
			pix_eof_o = (k == len - 1);
			pix_r_o = r;
			pix_g_o = g;
			pix_b_o = b;
			repeat (gap) begin
				@(negedge clk_i);
				idle();
			end
		end
		@(negedge clk_i);
		idle();
	endtask
endmodule // cwb_pix_src

/* sim/cwb_color_proc_test.sv */
// self-checking bench of the colour balance and ycc stage
`timescale 1ns/1ps
module cwb_color_proc_test;
	localparam int DW = 8;
	localparam int PER = 200;
	typedef struct {
		logic [7:0] r, g, b;
		logic [10:0] lum, sat;
		logic [7:0] y, cb, cr;
	} cwb_row_t;
	// ----------------------------------------------------------------
	// signals and instances
	// ----------------------------------------------------------------
	logic clk_i, reset_n_i, gain_write_i, balance_once_command_i;
	logic pix_valid_i, pix_sof_i, pix_eof_i;
	logic [7:0] pix_r_i, pix_g_i, pix_b_i, y_o, cb_o, cr_o;
	logic [1:0] auto_balance_mode_i, reference_channel_pick_i;
	logic [1:0] gain_channel_select_i, ref_channel_o;
	logic [8:0] channel_gain_value_i;
	logic [10:0] saturation_i, luminance_i;
	logic out_valid_o, out_sof_o, out_eof_o, balance_busy_o;
	logic [12:0] channel_gain_value_o;
	int err_total = 0;
	int num_checks = 0;
	int cyc = 0;
	cwb_row_t rows [10] = '{
		'{8'h64, 8'h64, 8'h64, 11'h100, 11'h400, 8'h64, 8'h80, 8'h80},
		'{8'h64, 8'h64, 8'h64, 11'h200, 11'h100, 8'hC8, 8'h80, 8'h80},
		'{8'h64, 8'h64, 8'h64, 11'h300, 11'h100, 8'hFF, 8'h80, 8'h80},
		'{8'h64, 8'h64, 8'h64, 11'h080, 11'h100, 8'h64, 8'h80, 8'h80},
		'{8'h32, 8'h32, 8'h32, 11'h500, 11'h100, 8'hC8, 8'h80, 8'h80},
		'{8'hFF, 8'h00, 8'h00, 11'h100, 11'h100, 8'h4C, 8'h54, 8'hFF},
		'{8'hFF, 8'h00, 8'h00, 11'h100, 11'h200, 8'h4C, 8'h28, 8'hFF},
		'{8'h00, 8'h00, 8'hFF, 11'h400, 11'h400, 8'h74, 8'hFF, 8'h2C},
		'{8'h00, 8'h00, 8'hFF, 11'h100, 11'h080, 8'h1D, 8'hFF, 8'h6B},
		'{8'h00, 8'hFF, 8'h00, 11'h100, 11'h200, 8'h95, 8'h00, 8'h00}};
	logic [8:0] hv [5] = '{9'h0C8, 9'h1C2, 9'h032, 9'h065, 9'h190};
	logic [12:0] gv [5] = '{13'h0800, 13'h1000, 13'h0400, 13'h040A,
		13'h1000};
	logic [12:0] ag [3] = '{13'h0400, 13'h0555, 13'h0A00};
	cwb_color_proc #(.DW(DW), .PERIOD_CYC(PER)) i_dut (
		.clk_i(clk_i),
		.reset_n_i(reset_n_i),
		.pix_valid_i(pix_valid_i),
		.pix_sof_i(pix_sof_i),
		.pix_eof_i(pix_eof_i),
		.pix_r_i(pix_r_i),
		.pix_g_i(pix_g_i),
		.pix_b_i(pix_b_i),
		.auto_balance_mode_i(auto_balance_mode_i),
		.balance_once_command_i(balance_once_command_i),
		.reference_channel_pick_i(reference_channel_pick_i),
		.gain_channel_select_i(gain_channel_select_i),
		.channel_gain_value_i(channel_gain_value_i),
		.gain_write_i(gain_write_i),
		.saturation_i(saturation_i),
		.luminance_i(luminance_i),
		.out_valid_o(out_valid_o),
		.out_sof_o(out_sof_o),
		.out_eof_o(out_eof_o),
		.y_o(y_o),
		.cb_o(cb_o),
		.cr_o(cr_o),
		.channel_gain_value_o(channel_gain_value_o),
		.ref_channel_o(ref_channel_o),
		.balance_busy_o(balance_busy_o)
	);
	cwb_pix_src #(.DW(DW)) i_src (
		.clk_i(clk_i),
		.pix_valid_o(pix_valid_i),
		.pix_sof_o(pix_sof_i),
		.pix_eof_o(pix_eof_i),
		.pix_r_o(pix_r_i),
		.pix_g_o(pix_g_i),
		.pix_b_o(pix_b_i)
	);
	// ----------------------------------------------------------------
	// tasks
	// ----------------------------------------------------------------
	task automatic tick(input int n);
		repeat (n) @(negedge clk_i);
	endtask
	task automatic chk(input string nm, input logic [12:0] e,
		input logic [12:0] s);
		num_checks++;
		if (s !== e) begin
			err_total++;
			$display("mismatch %s expected %h seen %h", nm, e, s);
		end
	endtask
	task automatic chk_pix(input logic [23:0] e);
		int n;
		n = 0;
		while (out_valid_o !== 1'b1 && n < 8) begin
			tick(1);
			n++;
		end
		num_checks++;
		// single-beat frames: valid, sof and eof all shown with the pixel
		if ({out_valid_o, out_sof_o, out_eof_o, y_o, cb_o, cr_o} !==
			{3'h7, e}) begin
			err_total++;
			$display("mismatch ycc expected %h seen %h", {3'h7, e},
				{out_valid_o, out_sof_o, out_eof_o, y_o, cb_o, cr_o});
		end
	endtask
	task automatic wr_gain(input logic [1:0] s, input logic [8:0] h);
		gain_channel_select_i = s;
		channel_gain_value_i = h;
		gain_write_i = 1'b1;
		tick(1);
		gain_write_i = 1'b0;
	endtask
	task automatic rd_gain(input logic [1:0] s, input logic [12:0] e);
		gain_channel_select_i = s;
		tick(2);
		chk("gain", e, channel_gain_value_o);
	endtask
	// bounded wait, the compare doubles as the timeout verdict
	task automatic wait_busy(input logic lvl, input int lim);
		int n;
		n = 0;
		while (balance_busy_o !== lvl && n < lim) begin
			tick(1);
			n++;
		end
		chk("busy", {12'h000, lvl}, {12'h000, balance_busy_o});
	endtask
	task automatic run_auto(input logic [1:0] s);
		gain_channel_select_i = s;
		balance_once_command_i = 1'b1;
		tick(1);
		balance_once_command_i = 1'b0;
		wait_busy(1'b1, 5);
		i_src.send_frame(4, 8'hC8, 8'h96, 8'h50, 1);
		wait_busy(1'b0, 1000);
		// select held on the reference a few cycles after the run ends
		tick(1);
		rd_gain(s, 13'h0400);
		chk("ref", {11'h000, s}, {11'h000, ref_channel_o});
	endtask
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", num_checks, err_total);
		if (err_total == 0 && num_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	// ----------------------------------------------------------------
	// clock, timeout, sequence
	// ----------------------------------------------------------------
	initial begin
		clk_i = 1'b0;
		forever #2.5 clk_i = ~clk_i;
	end
	always @(posedge clk_i) begin
		cyc++;
		if (cyc == 5000) begin
			err_total++;
			report_and_stop();
		end
	end
	initial begin
		reset_n_i = 1'b0;
		gain_write_i = 1'b0;
		balance_once_command_i = 1'b0;
		auto_balance_mode_i = 2'h0;
		reference_channel_pick_i = 2'h3;
		gain_channel_select_i = 2'h0;
		channel_gain_value_i = 9'h064;
		saturation_i = 11'h100;
		luminance_i = 11'h100;
		tick(20);
		reset_n_i = 1'b1;
		tick(1);
		chk("gain", 13'h0400, channel_gain_value_o);
		chk("ref", 13'h0001, {11'h000, ref_channel_o});
		$display("test reset done");
		foreach (rows[i]) begin
			luminance_i = rows[i].lum;
			saturation_i = rows[i].sat;
			i_src.send_frame(1, rows[i].r, rows[i].g, rows[i].b, 0);
			chk_pix({rows[i].y, rows[i].cb, rows[i].cr});
		end
		$display("test rows done");
		luminance_i = 11'h100;
		saturation_i = 11'h100;
		foreach (hv[i]) begin
			wr_gain(2'h0, hv[i]);
			rd_gain(2'h0, gv[i]);
		end
		// green stays at unity, red carries the balance
		wr_gain(2'h0, 9'h0C8);
		i_src.send_frame(1, 8'h64, 8'h00, 8'h00, 0);
		chk_pix(24'h3B5EE4);
		$display("test manual done");
		auto_balance_mode_i = 2'h2;
		i_src.send_frame(4, 8'hC8, 8'h96, 8'h50, 0);
		chk("busy", 13'h0000, {12'h000, balance_busy_o});
		run_auto(2'h0);
		for (int k = 0; k < 3; k++)
			rd_gain(2'(k), ag[k]);
		i_src.send_frame(1, 8'h64, 8'h64, 8'h64, 0);
		chk_pix(24'h88C065);
		wr_gain(2'h0, 9'h12C);
		rd_gain(2'h0, 13'h0400);
		reference_channel_pick_i = 2'h2;
		run_auto(2'h2);
		for (int k = 0; k < 3; k++)
			rd_gain(2'(k), 13'h0400);
		$display("test once done");
		reference_channel_pick_i = 2'h3;
		auto_balance_mode_i = 2'h1;
		wait_busy(1'b1, PER + 10);
		i_src.send_frame(4, 8'hC8, 8'h96, 8'h50, 0);
		wait_busy(1'b0, 1000);
		rd_gain(2'h2, 13'h0A00);
		auto_balance_mode_i = 2'h0;
		$display("test periodic done");
		report_and_stop();
	end
endmodule // cwb_color_proc_test
